/* File: hdl/timestamp_and_event_notify.sv */
// Purpose: 64-bit timestamp counter with latch/clear and an event notifier
// Assumes: inputs synchronous to clk_sys_in; APB slave with no wait states
// Notes: events leave one per cycle when the channel takes them
//
// What this block does
// - latch command copies counter to captured value
// - captured value is 64 bits, selected base
// - time base select picks local or network
// - precision mode forces network time base
// - ticks per second follows selected base
// - frame begin capture copies counter each frame
// - clear command zeroes the counter
// - clear zeroes local timer, and network timer only while precision mode is off
// - clear select none still honours command
// - input pin one or two clears counter
// - broadcast action two clears counter
// - polarity picks falling, rising or either edge
// - notify choice selects event's own enable
// - frame begin event sent per frame
// - exposure begin and finish events sent
// - rearm event when acquisition start allowed
// - accepted and rejected trigger events sent
// - dropped picture event on memory shortage
// - count one done event sent
// - four input pin edge events
// - overflow disables all events but the overrun notice, sends overrun
// - disabled events unsent, enabled sent; of those in one cycle only the lowest numbered
`timescale 1ns/1ps
`default_nettype none
module timestamp_and_event_notify (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic network_tick_in,
   input wire logic precision_mode_in,
   input wire logic input_pin_one_in,
   input wire logic input_pin_two_in,
   input wire logic broadcast_action_two_in,
   input wire tsn_pkg::camera_events_type camera_events_in,
   input wire logic channel_ready_in,
   output var tsn_pkg::event_message_type event_out
);
   logic [63:0] local_time, next_local_time;
   logic [63:0] network_time, next_network_time;
   logic [63:0] captured_time_value, next_captured_time_value;
   logic time_base_select, next_time_base_select;
   logic capture_trigger_select, next_capture_trigger_select;
   tsn_pkg::clear_trigger_type clear_trigger_select, next_clear_trigger_select;
   tsn_pkg::clear_edge_type clear_edge_polarity, next_clear_edge_polarity;
   logic [3:0] notify_choice, next_notify_choice;
   logic [tsn_pkg::num_events:0] notify_enable, next_notify_enable;
   logic pin_one_prev, pin_two_prev;
   logic [31:0] next_prdata;
   logic pslverr, next_pslverr;
   tsn_pkg::event_message_type queue [tsn_pkg::queue_depth];
   tsn_pkg::event_message_type next_slot;
   logic [2:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [3:0] fill, next_fill;
   tsn_pkg::event_message_type event_reg, next_event_reg;
   logic overrun_pending, next_overrun_pending;
   logic base_is_network, write_hit, latch_cmd, clear_cmd, hw_clear;
   logic [63:0] selected_time;
   logic [tsn_pkg::num_events-1:0] raw_events;
   logic one_up, one_down, two_up, two_down;

   function automatic logic edge_match(input logic prev, input logic now,
                                       input tsn_pkg::clear_edge_type pol);
      logic rise;
      logic fall;
      rise = now & ~prev;
      fall = prev & ~now;
      case (pol)
         tsn_pkg::high_to_low_transition: edge_match = fall;
         tsn_pkg::low_to_high_transition: edge_match = rise;
         tsn_pkg::either_transition: edge_match = rise | fall;
         default: edge_match = 1'b0;
      endcase
   endfunction : edge_match

   always_comb begin
      base_is_network = time_base_select | precision_mode_in;
      selected_time = base_is_network ? network_time : local_time;
      write_hit = psel_in & penable_in & pwrite_in;
      latch_cmd = write_hit && paddr_in == tsn_pkg::ctrl_addr && pwdata_in[tsn_pkg::latch_bit];
      clear_cmd = write_hit && paddr_in == tsn_pkg::ctrl_addr && pwdata_in[tsn_pkg::clear_bit];
      one_up = input_pin_one_in & ~pin_one_prev;
      one_down = pin_one_prev & ~input_pin_one_in;
      two_up = input_pin_two_in & ~pin_two_prev;
      two_down = pin_two_prev & ~input_pin_two_in;
      case (clear_trigger_select)
         tsn_pkg::clear_pin_one:
            hw_clear = edge_match(pin_one_prev, input_pin_one_in, clear_edge_polarity);
         tsn_pkg::clear_pin_two:
            hw_clear = edge_match(pin_two_prev, input_pin_two_in, clear_edge_polarity);
         tsn_pkg::clear_action_two: hw_clear = broadcast_action_two_in;
         default: hw_clear = 1'b0;
      endcase
      raw_events = {two_down, two_up, one_down, one_up, camera_events_in.count_one_done,
                    camera_events_in.picture_dropped, camera_events_in.trigger_rejected,
                    camera_events_in.trigger_accepted, camera_events_in.acq_rearm,
                    camera_events_in.exposure_finish, camera_events_in.exposure_begin,
                    camera_events_in.frame_begin};
   end

   // counters and capture
   always_comb begin
      next_local_time = local_time + tsn_pkg::time_one;
      // network time advances only on precision ticks; the engine itself is outside
      next_network_time = network_tick_in ? network_time + tsn_pkg::time_one : network_time;
      if (clear_cmd || hw_clear) begin
         next_local_time = tsn_pkg::time_zero;
         // the host turns precision mode off first, else the network timer keeps running
         if (!precision_mode_in) begin
            next_network_time = tsn_pkg::time_zero;
         end
      end
      next_captured_time_value = captured_time_value;
      if (latch_cmd) begin
         next_captured_time_value = selected_time;
      end else if (capture_trigger_select && camera_events_in.frame_begin) begin
         next_captured_time_value = selected_time;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         local_time <= tsn_pkg::time_zero;
         network_time <= tsn_pkg::time_zero;
         captured_time_value <= tsn_pkg::time_zero;
         pin_one_prev <= 1'b0;
         pin_two_prev <= 1'b0;
      end else begin
         local_time <= next_local_time;
         network_time <= next_network_time;
         captured_time_value <= next_captured_time_value;
         pin_one_prev <= input_pin_one_in;
         pin_two_prev <= input_pin_two_in;
      end
   end

   // register file
   always_comb begin
      next_time_base_select = time_base_select;
      next_capture_trigger_select = capture_trigger_select;
      next_clear_trigger_select = clear_trigger_select;
      next_clear_edge_polarity = clear_edge_polarity;
      next_notify_choice = notify_choice;
      next_notify_enable = notify_enable;
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (psel_in && !penable_in) begin
         case (paddr_in)
            tsn_pkg::ctrl_addr: next_prdata = 32'h0000_0000;
            tsn_pkg::cfg_addr: next_prdata = {22'h00_0000,
               2'(clear_edge_polarity), 2'h0, 2'(clear_trigger_select), 2'h0,
               capture_trigger_select, base_is_network};
            tsn_pkg::notify_addr: next_prdata = {23'h00_0000,
               notify_enable[notify_choice], 4'h0, notify_choice};
            tsn_pkg::capture_lo_addr: next_prdata = captured_time_value[31:0];
            tsn_pkg::capture_hi_addr: next_prdata = captured_time_value[63:32];
            tsn_pkg::rate_addr:
               next_prdata = base_is_network ? tsn_pkg::network_rate_hz
                                             : tsn_pkg::local_rate_hz;
            tsn_pkg::enables_addr: next_prdata = {19'h0_0000, notify_enable};
            tsn_pkg::precision_addr: next_prdata = {31'h0000_0000, precision_mode_in};
            default: next_pslverr = 1'b1;
         endcase
      end
      if (write_hit) begin
         case (paddr_in)
            tsn_pkg::cfg_addr: begin
               next_time_base_select = pwdata_in[tsn_pkg::base_bit];
               next_capture_trigger_select = pwdata_in[tsn_pkg::capture_bit];
               next_clear_trigger_select =
                  tsn_pkg::clear_trigger_type'(pwdata_in[tsn_pkg::clear_sel_lsb +: 2]);
               next_clear_edge_polarity =
                  tsn_pkg::clear_edge_type'(pwdata_in[tsn_pkg::polarity_lsb +: 2]);
            end
            tsn_pkg::notify_addr: begin
               next_notify_choice = pwdata_in[tsn_pkg::choice_lsb +: 4];
               if (pwdata_in[tsn_pkg::choice_lsb +: 4] <= 4'(tsn_pkg::num_events)) begin
                  next_notify_enable[pwdata_in[tsn_pkg::choice_lsb +: 4]] =
                     pwdata_in[tsn_pkg::enable_bit];
               end
            end
            default: ;
         endcase
      end
      if (overrun_pending) begin
         // the overrun notice itself stays enabled so the host learns of it
         next_notify_enable[tsn_pkg::num_events-1:0] = '0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         time_base_select <= 1'b0;
         capture_trigger_select <= 1'b0;
         clear_trigger_select <= tsn_pkg::clear_none;
         clear_edge_polarity <= tsn_pkg::low_to_high_transition;
         notify_choice <= 4'h0;
         notify_enable <= '0;
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b1;
         pslverr <= 1'b0;
      end else begin
         time_base_select <= next_time_base_select;
         capture_trigger_select <= next_capture_trigger_select;
         clear_trigger_select <= next_clear_trigger_select;
         clear_edge_polarity <= next_clear_edge_polarity;
         notify_choice <= next_notify_choice;
         notify_enable <= next_notify_enable;
         prdata_out <= next_prdata;
         // no wait states, but kept in a flop so every output is registered
         pready_out <= 1'b1;
         pslverr <= next_pslverr;
      end
   end
   always_comb pslverr_out = pslverr;

   // event message queue: of events pending in one cycle, only the lowest numbered enters
   always_comb begin
      next_slot = '0;
      for (int i = tsn_pkg::num_events - 1; i >= 0; i--) begin
         if (raw_events[i] && notify_enable[i]) begin
            next_slot.valid = 1'b1;
            next_slot.code = tsn_pkg::event_code_type'(i);
            next_slot.stamp = selected_time;
         end
      end
      next_overrun_pending = 1'b0;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_fill = fill;
      next_event_reg = event_reg;
      if (event_reg.valid && channel_ready_in) begin
         next_event_reg.valid = 1'b0;
      end
      if (!next_event_reg.valid && fill != 4'h0) begin
         next_event_reg = queue[rd_ptr];
         next_rd_ptr = rd_ptr + 3'h1;
         next_fill = next_fill - 4'h1;
      end
      if (next_slot.valid) begin
         if (fill == 4'(tsn_pkg::queue_depth)) begin
            next_overrun_pending = 1'b1;
         end else begin
            next_wr_ptr = wr_ptr + 3'h1;
            next_fill = next_fill + 4'h1;
         end
      end
      if (overrun_pending && notify_enable[tsn_pkg::num_events]) begin
         // overrun notice bypasses the full queue by replacing the outgoing slot
         next_event_reg.valid = 1'b1;
         next_event_reg.code = tsn_pkg::message_queue_overrun_evt;
         next_event_reg.stamp = selected_time;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         wr_ptr <= 3'h0;
         rd_ptr <= 3'h0;
         fill <= 4'h0;
         event_reg <= '0;
         overrun_pending <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fill <= next_fill;
         event_reg <= next_event_reg;
         overrun_pending <= next_overrun_pending;
         if (next_slot.valid && fill != 4'(tsn_pkg::queue_depth)) begin
            queue[wr_ptr] <= next_slot;
         end
      end
   end
   always_comb event_out = event_reg;

   a_latch_copies: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      latch_cmd |=> captured_time_value == $past(selected_time))
      else $error("latch did not capture counter");
   a_precision_forces: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      precision_mode_in |-> selected_time == network_time)
      else $error("precision mode did not force network base");
   a_rate_tracks: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      psel_in && !penable_in && paddr_in == tsn_pkg::rate_addr && base_is_network
      |=> prdata_out == tsn_pkg::network_rate_hz)
      else $error("tick rate wrong for base");
   a_frame_capture: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      capture_trigger_select && camera_events_in.frame_begin && !latch_cmd
      |=> captured_time_value == $past(selected_time))
      else $error("frame begin did not capture");
   a_clear_zeroes: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      clear_cmd |=> local_time == tsn_pkg::time_zero)
      else $error("clear did not zero counter");
   a_clear_network: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      clear_cmd && !precision_mode_in |=> network_time == tsn_pkg::time_zero)
      else $error("clear missed network timer");
   a_pin_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      clear_trigger_select == tsn_pkg::clear_pin_two &&
      clear_edge_polarity == tsn_pkg::low_to_high_transition && two_up
      |=> local_time == tsn_pkg::time_zero)
      else $error("pin edge did not clear");
   a_action_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      clear_trigger_select == tsn_pkg::clear_action_two && broadcast_action_two_in
      |=> local_time == tsn_pkg::time_zero)
      else $error("action did not clear");
   a_counter_step: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      !reset_in && !clear_cmd && !hw_clear
      |=> local_time == $past(local_time) + tsn_pkg::time_one)
      else $error("counter did not step");
   a_overrun_disables: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      overrun_pending |=> notify_enable[tsn_pkg::num_events-1:0] == '0)
      else $error("overflow did not disable events");
   a_disabled_silent: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      (raw_events & notify_enable[tsn_pkg::num_events-1:0]) == '0
      |-> !next_slot.valid)
      else $error("disabled event queued");
   // an enabled event into an idle path reaches the channel two edges later
   sequence s_lone_event;
      fill == 4'h0 && !event_reg.valid && next_slot.valid && !overrun_pending;
   endsequence
   a_event_delivered: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      s_lone_event |=> ##1 event_out.valid && event_out.code == $past(next_slot.code, 2))
      else $error("enabled event not delivered");
endmodule : timestamp_and_event_notify
`default_nettype wire

/* File: shared/tsn_pkg.sv */
// Purpose: constants and types for the timestamp and event notify block
// Assumes: 32-bit APB, 200 MHz system clock
// Notes: register offsets are byte addresses
package tsn_pkg;
   localparam logic [11:0] ctrl_addr = 12'h000;
   localparam logic [11:0] cfg_addr = 12'h004;
   localparam logic [11:0] notify_addr = 12'h008;
   localparam logic [11:0] capture_lo_addr = 12'h00C;
   localparam logic [11:0] capture_hi_addr = 12'h010;
   localparam logic [11:0] rate_addr = 12'h014;
   localparam logic [11:0] enables_addr = 12'h018;
   localparam logic [11:0] precision_addr = 12'h01C;
   // ctrl bits, write-one commands
   localparam int latch_bit = 0;
   localparam int clear_bit = 1;
   // cfg fields
   localparam int base_bit = 0;
   localparam int capture_bit = 1;
   localparam int clear_sel_lsb = 4;
   localparam int polarity_lsb = 8;
   // notify fields
   localparam int choice_lsb = 0;
   localparam int enable_bit = 8;
   localparam int num_events = 12;
   localparam int queue_depth = 8;
   localparam logic [31:0] local_rate_hz = 32'h0BEB_C200;
   localparam logic [31:0] network_rate_hz = 32'h3B9A_CA00;
   localparam logic [63:0] time_one = 64'h0000_0000_0000_0001;
   localparam logic [63:0] time_zero = 64'h0000_0000_0000_0000;
   typedef enum logic [1:0] {clear_none, clear_pin_one, clear_pin_two, clear_action_two}
      clear_trigger_type;
   typedef enum logic [1:0] {high_to_low_transition, low_to_high_transition,
      either_transition} clear_edge_type;
   typedef enum logic [3:0] {frame_begin_evt, exposure_begin_evt, exposure_finish_evt,
      acq_rearm_evt, accepted_trigger_evt, rejected_trigger_evt, dropped_picture_evt,
      count_one_done_evt, pin_one_up_evt, pin_one_down_evt, pin_two_up_evt,
      pin_two_down_evt, message_queue_overrun_evt} event_code_type;
   typedef struct packed {
      logic frame_begin;
      logic exposure_begin;
      logic exposure_finish;
      logic acq_rearm;
      logic trigger_accepted;
      logic trigger_rejected;
      logic picture_dropped;
      logic count_one_done;
   } camera_events_type;
   typedef struct packed {
      logic valid;
      event_code_type code;
      logic [63:0] stamp;
   } event_message_type;
endpackage : tsn_pkg

/* File: tb/host_channel_model.sv */
// Purpose: control channel receiver standing in for the host application
// Assumes: event_in holds valid until it is taken at an edge with ready_out high
// Notes: stall_in keeps ready low to play a slow host, so the message queue can back up
`timescale 1ns/1ps
`default_nettype none
module host_channel_model (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic stall_in,
   input wire tsn_pkg::event_message_type event_in,
   output logic ready_out,
   output logic [3:0] last_code_out,
   output logic [15:0] count_out,
   output logic overrun_seen_out
);
   assign ready_out = !stall_in;
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         last_code_out <= 4'hF;
         count_out <= 16'h0000;
         overrun_seen_out <= 1'h0;
      end else if (event_in.valid === 1'h1 && ready_out) begin
         last_code_out <= event_in.code;
         count_out <= count_out + 16'h0001;
         if (event_in.code == tsn_pkg::message_queue_overrun_evt) begin
            overrun_seen_out <= 1'h1;
         end
      end
   end
endmodule : host_channel_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the timestamp and event notify block
// Assumes: APB slave answers in the access cycle; 200 MHz clock
// Notes: timestamp deltas are timed from the bench's own cycle count
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_sys_in = 1'h0;
   logic reset_in = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr, ready, ov_seen;
   logic tick = 1'h0, prec = 1'h0, pin1 = 1'h0, pin2 = 1'h0, act2 = 1'h0, stall = 1'h0;
   tsn_pkg::camera_events_type cam = '0;
   tsn_pkg::event_message_type evt;
   logic [3:0] last_code;
   logic [15:0] count, cnt0;
   logic [63:0] cap, v1, lt1, t0;
   logic [5:0] cases [6] = '{6'h10, 6'h10, 6'h25, 6'h29, 6'h36, 6'h04};
   logic expect_clr [6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
   int n_fail = 0;
   int total_checks = 0;
   longint cyc = 0, take = 0;
   initial begin
      forever #2.5 clk_sys_in = !clk_sys_in;
   end
   always @(posedge clk_sys_in) cyc <= cyc + 1;
   timestamp_and_event_notify i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .network_tick_in(tick), .precision_mode_in(prec), .input_pin_one_in(pin1),
      .input_pin_two_in(pin2), .broadcast_action_two_in(act2), .camera_events_in(cam),
      .channel_ready_in(ready), .event_out(evt));
   host_channel_model i_host (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .stall_in(stall),
      .event_in(evt), .ready_out(ready), .last_code_out(last_code), .count_out(count),
      .overrun_seen_out(ov_seen));
   task automatic conclude;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic hang(input string what);
      n_fail++;
      $display("[FAIL] %s expected done seen timeout", what);
      conclude();
   endtask : hang
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'h1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'h1 && n < 16);
      if (pready !== 1'h1) hang("apb");
      rdata = prdata;
      rerr = pslverr;
      take = cyc;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0000_0000);
      chk(what, {32'h0, exp}, {32'h0, rdata});
   endtask : rd_chk
   task automatic rdcap;
      apb(1'h0, tsn_pkg::capture_lo_addr, 32'h0000_0000);
      cap[31:0] = rdata;
      apb(1'h0, tsn_pkg::capture_hi_addr, 32'h0000_0000);
      cap[63:32] = rdata;
   endtask : rdcap
   task automatic latch;
      apb(1'h1, tsn_pkg::ctrl_addr, 32'h0000_0001);
      lt1 = take;
      rdcap();
   endtask : latch
   task automatic pulse_cam(input int k);
      @(posedge clk_sys_in);
      cam <= tsn_pkg::camera_events_type'(8'h80 >> k);
      @(posedge clk_sys_in);
      cam <= '0;
   endtask : pulse_cam
   task automatic wait_evt(input logic [3:0] code, input logic sent);
      int n;
      n = 0;
      while (count === cnt0 && n < 12) begin
         @(posedge clk_sys_in);
         n++;
      end
      chk("event sent", {63'h0, sent}, {63'h0, count !== cnt0});
      if (sent) chk("event code", {60'h0, code}, {60'h0, last_code});
   endtask : wait_evt
   function automatic logic [31:0] cfgv(input logic [1:0] s, input logic [1:0] p,
         input logic [1:0] low);
      return {22'h0, p, 2'h0, s, 2'h0, low};
   endfunction : cfgv
   initial begin
      repeat (50000) @(posedge clk_sys_in);
      hang("run");
   end
   initial begin
      repeat (6) @(posedge clk_sys_in);
      reset_in <= 1'h0;
      rd_chk("cfg", tsn_pkg::cfg_addr, 32'h0000_0100);
      rd_chk("notify", tsn_pkg::notify_addr, 32'h0000_0000);
      rd_chk("enables", tsn_pkg::enables_addr, 32'h0000_0000);
      rd_chk("precision", tsn_pkg::precision_addr, 32'h0000_0000);
      rd_chk("rate local", tsn_pkg::rate_addr, tsn_pkg::local_rate_hz);
      apb(1'h1, tsn_pkg::rate_addr, 32'h0000_0000);
      rd_chk("rate read only", tsn_pkg::rate_addr, tsn_pkg::local_rate_hz);
      apb(1'h0, 12'h0FC, 32'h0000_0000);
      chk("unmapped err", 64'h1, {63'h0, rerr});
      $display("test registers done");
      latch();
      v1 = cap;
      t0 = lt1;
      latch();
      chk("latch delta", lt1 - t0, cap - v1);
      v1 = cap;
      t0 = lt1;
      repeat (20) @(posedge clk_sys_in);
      latch();
      chk("local delta", lt1 - t0, cap - v1);
      v1 = cap;
      rdcap();
      chk("latch holds", v1, cap);
      $display("test latch done");
      apb(1'h1, tsn_pkg::ctrl_addr, 32'h0000_0002);
      t0 = take;
      latch();
      chk("clear exact", lt1 - t0 - 64'h1, cap);
      apb(1'h1, tsn_pkg::cfg_addr, cfgv(2'h0, 2'h1, 2'h1));
      rd_chk("rate network", tsn_pkg::rate_addr, tsn_pkg::network_rate_hz);
      latch();
      v1 = cap;
      repeat (5) begin
         @(posedge clk_sys_in) tick <= 1'h1;
         @(posedge clk_sys_in) tick <= 1'h0;
      end
      latch();
      chk("network delta", v1 + 64'h5, cap);
      prec <= 1'h0;
      apb(1'h1, tsn_pkg::ctrl_addr, 32'h0000_0002);
      latch();
      chk("network cleared", tsn_pkg::time_zero, cap);
      @(posedge clk_sys_in) prec <= 1'h1;
      @(posedge clk_sys_in) tick <= 1'h1;
      @(posedge clk_sys_in) tick <= 1'h0;
      apb(1'h1, tsn_pkg::ctrl_addr, 32'h0000_0002);
      latch();
      chk("network kept", 64'h1, cap);
      apb(1'h1, tsn_pkg::cfg_addr, cfgv(2'h0, 2'h1, 2'h0));
      @(posedge clk_sys_in) prec <= 1'h1;
      rd_chk("forced base", tsn_pkg::cfg_addr, 32'h0000_0101);
      rd_chk("forced rate", tsn_pkg::rate_addr, tsn_pkg::network_rate_hz);
      rd_chk("precision on", tsn_pkg::precision_addr, 32'h0000_0001);
      @(posedge clk_sys_in) prec <= 1'h0;
      $display("test time base done");
      for (int k = 0; k < 6; k++) begin
         apb(1'h1, tsn_pkg::cfg_addr, cfgv(cases[k][5:4], cases[k][3:2], 2'h0));
         repeat (40) @(posedge clk_sys_in);
         @(posedge clk_sys_in);
         if (cases[k][1:0] == 2'h0) pin1 <= !pin1;
         else if (cases[k][1:0] == 2'h1) pin2 <= !pin2;
         else act2 <= 1'h1;
         @(posedge clk_sys_in) act2 <= 1'h0;
         latch();
         chk("hw clear", {63'h0, expect_clr[k]}, {63'h0, cap < 64'h10});
      end
      $display("test hardware clear done");
      apb(1'h1, tsn_pkg::cfg_addr, cfgv(2'h0, 2'h1, 2'h2));
      latch();
      v1 = cap;
      pulse_cam(0);
      repeat (3) @(posedge clk_sys_in);
      rdcap();
      chk("frame capture", 64'h1, {63'h0, cap > v1});
      v1 = cap;
      repeat (10) @(posedge clk_sys_in);
      rdcap();
      chk("capture holds", v1, cap);
      $display("test frame capture done");
      for (int k = 0; k < 12; k++) begin
         if (k >= 8) begin
            @(posedge clk_sys_in);
            if (k < 10) pin1 <= k[0];
            else pin2 <= k[0];
            repeat (3) @(posedge clk_sys_in);
         end
         apb(1'h1, tsn_pkg::notify_addr, 32'(k) | 32'h0000_0100);
         if (k == 0) rd_chk("notify readback", tsn_pkg::notify_addr, 32'h0000_0100);
         cnt0 = count;
         if (k < 8) pulse_cam(k);
         else if (k < 10) pin1 <= !k[0];
         else pin2 <= !k[0];
         wait_evt(4'(k), 1'h1);
         apb(1'h1, tsn_pkg::notify_addr, 32'(k));
      end
      cnt0 = count;
      pulse_cam(0);
      wait_evt(4'h0, 1'h0);
      $display("test events done");
      apb(1'h1, tsn_pkg::notify_addr, 32'h0000_010C);
      apb(1'h1, tsn_pkg::notify_addr, 32'h0000_0100);
      @(posedge clk_sys_in) stall <= 1'h1;
      repeat (12) pulse_cam(0);
      rd_chk("enables after overflow", tsn_pkg::enables_addr, 32'h0000_1000);
      @(posedge clk_sys_in) stall <= 1'h0;
      repeat (30) @(posedge clk_sys_in);
      chk("overrun sent", 64'h1, {63'h0, ov_seen});
      apb(1'h1, tsn_pkg::notify_addr, 32'h0000_0100);
      cnt0 = count;
      pulse_cam(0);
      wait_evt(4'h0, 1'h1);
      $display("test overflow done");
      conclude();
   end
endmodule : tb
`default_nettype wire
